// File: sqc_pkg.sv
// Package of the switch QoS block: register map, field positions,
// reset values, code points, scheduler modes and timing counts.
// Assumes a single 100 MHz system clock.
package sqc_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned NPORT = 8;
	localparam int unsigned IDW   = 8;
	localparam int unsigned DEPTH = 8;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_PORT_EN   = 8'h04;
	localparam logic [7:0] OFS_USER_CP   = 8'h08;
	localparam logic [7:0] OFS_NETA_ADDR = 8'h0C;
	localparam logic [7:0] OFS_NETA_MASK = 8'h10;
	localparam logic [7:0] OFS_NETB_ADDR = 8'h14;
	localparam logic [7:0] OFS_NETB_MASK = 8'h18;
	localparam logic [7:0] OFS_STATUS    = 8'h1C;

	// ==========================================================
	// Field positions
	localparam int unsigned CTL_MODE_LSB = 0;
	localparam int unsigned CTL_UCPA_EN  = 4;
	localparam int unsigned CTL_UCPB_EN  = 5;
	localparam int unsigned CTL_NETA_EN  = 6;
	localparam int unsigned CTL_NETB_EN  = 7;
	localparam int unsigned CTL_THR_LSB  = 8;
	localparam int unsigned PEN_PORT_LSB = 0;
	localparam int unsigned PEN_PCP_LSB  = 8;
	localparam int unsigned PEN_DSCP_LSB = 16;
	localparam int unsigned UCP_A_LSB    = 0;
	localparam int unsigned UCP_B_LSB    = 8;

	// ==========================================================
	// Write masks and reset values
	localparam logic [31:0] CTRL_WMASK = 32'h0000_07F3;
	localparam logic [31:0] PEN_WMASK  = 32'h00FF_FFFF;
	localparam logic [31:0] UCP_WMASK  = 32'h0000_3F3F;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0400;
	localparam logic [31:0] PEN_RST    = 32'h0000_0000;
	localparam logic [31:0] UCP_RST    = 32'h0000_0000;
	localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
	localparam logic [31:0] MASK_RST   = 32'hFFFF_FFFF;

	// ==========================================================
	// Scheduler modes and ratios
	localparam logic [1:0] MODE_R4     = 2'h0;
	localparam logic [1:0] MODE_R8     = 2'h1;
	localparam logic [1:0] MODE_R16    = 2'h2;
	localparam logic [1:0] MODE_STRICT = 2'h3;
	localparam logic [4:0] RATIO_4     = 5'h04;
	localparam logic [4:0] RATIO_8     = 5'h08;
	localparam logic [4:0] RATIO_16    = 5'h10;

	function automatic logic [4:0] ratio_n(input logic [1:0] m);
		case (m)
			MODE_R4: ratio_n = RATIO_4;
			MODE_R8: ratio_n = RATIO_8;
			default: ratio_n = RATIO_16;
		endcase
	endfunction

	// ==========================================================
	// Fixed high priority code points
	localparam logic [5:0] DSCP_EF   = 6'h2E;
	localparam logic [5:0] DSCP_AF11 = 6'h0A;
	localparam logic [5:0] DSCP_AF21 = 6'h12;
	localparam logic [5:0] DSCP_AF31 = 6'h1A;
	localparam logic [5:0] DSCP_AF41 = 6'h22;
	localparam logic [5:0] DSCP_NC7  = 6'h38;
	localparam logic [5:0] DSCP_NC6  = 6'h30;

	function automatic logic dscp_default(input logic [5:0] d);
		dscp_default = (d == DSCP_EF) || (d == DSCP_AF11) ||
			(d == DSCP_AF21) || (d == DSCP_AF31) ||
			(d == DSCP_AF41) || (d == DSCP_NC7) || (d == DSCP_NC6);
	endfunction

	function automatic logic net_match(input logic [31:0] a,
		input logic [31:0] net, input logic [31:0] mask);
		net_match = ((a ^ net) & mask) == 32'h0000_0000;
	endfunction

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned LED_HALF_MS  = 50;
	localparam int unsigned LED_HALF_CYC = CLK_HZ / 1000 * LED_HALF_MS;

endpackage

// File: sqc_classify.sv
// Priority classifier: combines the enabled methods for one packet.
// Assumes the caller has picked the per-port enables for the ingress port.
module sqc_classify (
	// Per-port enables
	input  wire logic        i_port_en,
	input  wire logic        i_pcp_en,
	input  wire logic        i_dscp_en,
	// Switch-wide settings
	input  wire logic [2:0]  i_thr,
	input  wire logic        i_ucpa_en,
	input  wire logic        i_ucpb_en,
	input  wire logic [5:0]  i_ucpa,
	input  wire logic [5:0]  i_ucpb,
	input  wire logic        i_neta_en,
	input  wire logic        i_netb_en,
	input  wire logic [31:0] i_neta_addr,
	input  wire logic [31:0] i_neta_mask,
	input  wire logic [31:0] i_netb_addr,
	input  wire logic [31:0] i_netb_mask,
	// Packet fields
	input  wire logic        i_tagged,
	input  wire logic [2:0]  i_pcp,
	input  wire logic        i_is_ip,
	input  wire logic [5:0]  i_dscp,
	input  wire logic [31:0] i_src_ip,
	input  wire logic [31:0] i_dst_ip,
	// Result
	output logic             o_high
);

	logic by_port;
	logic by_pcp;
	logic by_dscp;
	logic in_a;
	logic in_b;
	logic by_net;

	assign by_port = i_port_en;
	assign by_pcp  = i_pcp_en && i_tagged && (i_pcp >= i_thr);
	assign by_dscp = i_dscp_en && i_is_ip &&
		(sqc_pkg::dscp_default(i_dscp) ||
		(i_ucpa_en && i_dscp == i_ucpa) ||
		(i_ucpb_en && i_dscp == i_ucpb));
	assign in_a = sqc_pkg::net_match(i_src_ip, i_neta_addr, i_neta_mask) ||
		sqc_pkg::net_match(i_dst_ip, i_neta_addr, i_neta_mask);
	assign in_b = sqc_pkg::net_match(i_src_ip, i_netb_addr, i_netb_mask) ||
		sqc_pkg::net_match(i_dst_ip, i_netb_addr, i_netb_mask);
	assign by_net = i_is_ip &&
		((i_neta_en && in_a) || (i_netb_en && in_b));

	assign o_high = by_port || by_pcp || by_dscp || by_net;

endmodule

// File: sqc_link_led.sv
// Link and activity indicator for every port.
// Assumes link levels already synchronised and activity as one-cycle pulses.
module sqc_link_led #(
	parameter int unsigned NP       = 8,
	parameter int unsigned HALF_CYC = 5_000_000
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_resetn,
	// Port state
	input  wire logic [NP-1:0] i_up,
	input  wire logic [NP-1:0] i_act,
	// Indicators
	output logic      [NP-1:0] o_led
);

	logic [31:0]   div_q;
	logic          tick;
	logic          phase_q;
	logic [NP-1:0] seen_q;
	logic [NP-1:0] busy_q;
	logic [NP-1:0] led_d;

	assign tick = div_q == 32'(HALF_CYC - 1);
	// Blink while traffic seen in the last half period, else steady
	assign led_d = i_up & (~busy_q | {NP{phase_q}});

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			div_q   <= 32'h0000_0000;
			phase_q <= 1'b0;
			seen_q  <= '0;
			busy_q  <= '0;
			o_led   <= '0;
		end else begin
			div_q   <= tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
			phase_q <= phase_q ^ tick;
			seen_q  <= i_act | (seen_q & {NP{~tick}});
			if (tick) begin
				busy_q <= seen_q | i_act;
			end
			o_led   <= led_d;
		end
	end

	property p_led_down;
		@(posedge i_clk) disable iff (!i_resetn)
		!i_up[0] |=> !o_led[0];
	endproperty
	a_led_down: assert property (p_led_down)
		else $error("indicator lit with link down");

	property p_led_idle;
		@(posedge i_clk) disable iff (!i_resetn)
		i_up[0] && !busy_q[0] |=> o_led[0];
	endproperty
	a_led_idle: assert property (p_led_idle)
		else $error("indicator dark on idle link");

endmodule

// File: sqc_top.sv
// Per-port QoS block: classifier, two egress queues per port, scheduler,
// register port and link indicators.
// Assumes forwarding engine and transmitters share i_clk; link pins async.
//
// Contract
// - Two transmit queues per egress port
// - Weighted modes send N high then one low
// - Strict mode: low only when high empty
// - Any enabled method high gives high
// - Port enable makes every packet high
// - Tagged user priority at threshold is high
// - DSCP method only when port's DSCP enable set
// - Fixed code points classify high
// - User code points classify high when enabled
// - Each user code point has own enable
// - Source or destination in network is high
// - Each network has own enable
// - Indicator on idle, blinking busy, off down
// - Network match is address under mask
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module sqc_top #(
	parameter int unsigned NP       = sqc_pkg::NPORT,
	parameter int unsigned IDW      = sqc_pkg::IDW,
	parameter int unsigned DEPTH    = sqc_pkg::DEPTH,
	parameter int unsigned HALF_CYC = sqc_pkg::LED_HALF_CYC
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	// Register port
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	// Ingress descriptors
	input  wire logic              i_pkt_valid,
	output logic                   o_pkt_ready,
	input  wire logic [2:0]        i_pkt_port,
	input  wire logic [2:0]        i_pkt_egress,
	input  wire logic [IDW-1:0]    i_pkt_id,
	input  wire logic              i_pkt_tagged,
	input  wire logic [2:0]        i_pkt_pcp,
	input  wire logic              i_pkt_is_ip,
	input  wire logic [5:0]        i_pkt_dscp,
	input  wire logic [31:0]       i_pkt_src_ip,
	input  wire logic [31:0]       i_pkt_dst_ip,
	// Egress transmitters
	output logic      [NP-1:0]     o_tx_valid,
	output logic      [NP-1:0]     o_tx_high,
	output logic      [NP*IDW-1:0] o_tx_id,
	input  wire logic [NP-1:0]     i_tx_ready,
	// Link pins and indicators
	input  wire logic [NP-1:0]     i_link_up,
	output logic      [NP-1:0]     o_link_activity_indicator
);

	localparam int unsigned NQ = 2 * NP;
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam int unsigned QW = $clog2(NQ);

	// ==========================================================
	// Registers
	logic [31:0] ctrl_q;
	logic [31:0] pen_q;
	logic [31:0] ucp_q;
	logic [31:0] neta_addr_q;
	logic [31:0] neta_mask_q;
	logic [31:0] netb_addr_q;
	logic [31:0] netb_mask_q;
	logic [31:0] status;
	logic [31:0] rd_mux;

	logic [1:0]  mode;
	logic        strict;
	logic [4:0]  ratio;
	logic [NP-1:0] en_port;
	logic [NP-1:0] en_pcp;
	logic [NP-1:0] en_dscp;

	assign mode    = ctrl_q[sqc_pkg::CTL_MODE_LSB +: 2];
	assign strict  = mode == sqc_pkg::MODE_STRICT;
	assign ratio   = sqc_pkg::ratio_n(mode);
	assign en_port = pen_q[sqc_pkg::PEN_PORT_LSB +: NP];
	assign en_pcp  = pen_q[sqc_pkg::PEN_PCP_LSB +: NP];
	assign en_dscp = pen_q[sqc_pkg::PEN_DSCP_LSB +: NP];

	assign rd_mux =
		(i_addr == sqc_pkg::OFS_CTRL)      ? ctrl_q :
		(i_addr == sqc_pkg::OFS_PORT_EN)   ? pen_q :
		(i_addr == sqc_pkg::OFS_USER_CP)   ? ucp_q :
		(i_addr == sqc_pkg::OFS_NETA_ADDR) ? neta_addr_q :
		(i_addr == sqc_pkg::OFS_NETA_MASK) ? neta_mask_q :
		(i_addr == sqc_pkg::OFS_NETB_ADDR) ? netb_addr_q :
		(i_addr == sqc_pkg::OFS_NETB_MASK) ? netb_mask_q :
		(i_addr == sqc_pkg::OFS_STATUS)    ? status :
		32'h0000_0000;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ctrl_q      <= sqc_pkg::CTRL_RST;
			pen_q       <= sqc_pkg::PEN_RST;
			ucp_q       <= sqc_pkg::UCP_RST;
			neta_addr_q <= sqc_pkg::ADDR_RST;
			neta_mask_q <= sqc_pkg::MASK_RST;
			netb_addr_q <= sqc_pkg::ADDR_RST;
			netb_mask_q <= sqc_pkg::MASK_RST;
			o_rdata     <= 32'h0000_0000;
		end else begin
			if (i_wr && i_addr == sqc_pkg::OFS_CTRL) begin
				ctrl_q <= i_wdata & sqc_pkg::CTRL_WMASK;
			end
			if (i_wr && i_addr == sqc_pkg::OFS_PORT_EN) begin
				pen_q <= i_wdata & sqc_pkg::PEN_WMASK;
			end
			if (i_wr && i_addr == sqc_pkg::OFS_USER_CP) begin
				ucp_q <= i_wdata & sqc_pkg::UCP_WMASK;
			end
			if (i_wr && i_addr == sqc_pkg::OFS_NETA_ADDR) begin
				neta_addr_q <= i_wdata;
			end
			if (i_wr && i_addr == sqc_pkg::OFS_NETA_MASK) begin
				neta_mask_q <= i_wdata;
			end
			if (i_wr && i_addr == sqc_pkg::OFS_NETB_ADDR) begin
				netb_addr_q <= i_wdata;
			end
			if (i_wr && i_addr == sqc_pkg::OFS_NETB_MASK) begin
				netb_mask_q <= i_wdata;
			end
			o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Classification
	logic          cls_high;
	logic          acc;
	logic [QW-1:0] tgt;

	sqc_classify u_classify (
		.i_port_en   (en_port[i_pkt_port]),
		.i_pcp_en    (en_pcp[i_pkt_port]),
		.i_dscp_en   (en_dscp[i_pkt_port]),
		.i_thr       (ctrl_q[sqc_pkg::CTL_THR_LSB +: 3]),
		.i_ucpa_en   (ctrl_q[sqc_pkg::CTL_UCPA_EN]),
		.i_ucpb_en   (ctrl_q[sqc_pkg::CTL_UCPB_EN]),
		.i_ucpa      (ucp_q[sqc_pkg::UCP_A_LSB +: 6]),
		.i_ucpb      (ucp_q[sqc_pkg::UCP_B_LSB +: 6]),
		.i_neta_en   (ctrl_q[sqc_pkg::CTL_NETA_EN]),
		.i_netb_en   (ctrl_q[sqc_pkg::CTL_NETB_EN]),
		.i_neta_addr (neta_addr_q),
		.i_neta_mask (neta_mask_q),
		.i_netb_addr (netb_addr_q),
		.i_netb_mask (netb_mask_q),
		.i_tagged    (i_pkt_tagged),
		.i_pcp       (i_pkt_pcp),
		.i_is_ip     (i_pkt_is_ip),
		.i_dscp      (i_pkt_dscp),
		.i_src_ip    (i_pkt_src_ip),
		.i_dst_ip    (i_pkt_dst_ip),
		.o_high      (cls_high)
	);

	assign acc = i_pkt_valid && o_pkt_ready;
	// Queue index: egress port times two, plus one for high
	assign tgt = QW'({i_pkt_egress, cls_high});

	// ==========================================================
	// Queues, two per port
	logic [IDW-1:0] mem_q  [NQ][DEPTH];
	logic [PW-1:0]  wp_q   [NQ];
	logic [PW-1:0]  rp_q   [NQ];
	logic [CW-1:0]  cnt_q  [NQ];
	logic [CW-1:0]  cnt_d  [NQ];
	logic [IDW-1:0] head   [NQ];
	logic [NQ-1:0]  push;
	logic [NQ-1:0]  pop;
	logic [NQ-1:0]  ne;
	logic [NQ-1:0]  room;

	for (genvar q = 0; q < NQ; q++) begin : g_q
		assign push[q]  = acc && (tgt == QW'(q));
		assign cnt_d[q] = cnt_q[q] + CW'(push[q]) - CW'(pop[q]);
		assign head[q]  = mem_q[q][rp_q[q]];
		assign ne[q]    = cnt_q[q] != '0;
		assign room[q]  = cnt_d[q] < CW'(DEPTH);

		always_ff @(posedge i_clk) begin
			if (!i_resetn) begin
				wp_q[q]  <= '0;
				rp_q[q]  <= '0;
				cnt_q[q] <= '0;
			end else begin
				if (push[q]) begin
					mem_q[q][wp_q[q]] <= i_pkt_id;
					wp_q[q] <= wp_q[q] + PW'(1);
				end
				if (pop[q]) begin
					rp_q[q] <= rp_q[q] + PW'(1);
				end
				cnt_q[q] <= cnt_d[q];
			end
		end
	end

	// Ready from next counts keeps a registered ready honest
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_pkt_ready <= 1'b0;
		end else begin
			o_pkt_ready <= &room;
		end
	end

	// ==========================================================
	// Egress scheduler, one per port
	logic [4:0]     rc_q   [NP];
	logic [IDW-1:0] txid_q [NP];
	logic [NP-1:0]  load;
	logic [NP-1:0]  sel_hi;
	logic [NP-1:0]  hi_ne;
	logic [NP-1:0]  lo_ne;
	logic [NP-1:0]  due_lo;

	for (genvar p = 0; p < NP; p++) begin : g_p
		assign hi_ne[p]  = ne[2*p+1];
		assign lo_ne[p]  = ne[2*p];
		assign load[p]   = (!o_tx_valid[p] || i_tx_ready[p]) &&
			(hi_ne[p] || lo_ne[p]);
		assign due_lo[p] = (rc_q[p] >= ratio) && lo_ne[p];
		// Empty high queue lets low go at once
		assign sel_hi[p] = strict ? hi_ne[p] :
			(hi_ne[p] && !due_lo[p]);
		assign pop[2*p+1] = load[p] && sel_hi[p];
		assign pop[2*p]   = load[p] && !sel_hi[p];
		assign o_tx_id[p*IDW +: IDW] = txid_q[p];

		always_ff @(posedge i_clk) begin
			if (!i_resetn) begin
				o_tx_valid[p] <= 1'b0;
				o_tx_high[p]  <= 1'b0;
				txid_q[p]     <= '0;
				rc_q[p]       <= 5'h00;
			end else if (load[p]) begin
				o_tx_valid[p] <= 1'b1;
				o_tx_high[p]  <= sel_hi[p];
				txid_q[p]     <= sel_hi[p] ? head[2*p+1] : head[2*p];
				if (!sel_hi[p]) begin
					rc_q[p] <= 5'h00;
				end else if (rc_q[p] < ratio) begin
					rc_q[p] <= rc_q[p] + 5'h01;
				end
			end else if (i_tx_ready[p]) begin
				o_tx_valid[p] <= 1'b0;
			end
		end
	end

	assign status = {16'h0000, lo_ne, hi_ne};

	// ==========================================================
	// Link indicators
	logic [NP-1:0] link_s1_q;
	logic [NP-1:0] link_s2_q;
	logic [NP-1:0] act;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			link_s1_q <= '0;
			link_s2_q <= '0;
		end else begin
			link_s1_q <= i_link_up;
			link_s2_q <= link_s1_q;
		end
	end

	assign act = (o_tx_valid & i_tx_ready) |
		({{(NP-1){1'b0}}, acc} << i_pkt_port);

	sqc_link_led #(
		.NP       (NP),
		.HALF_CYC (HALF_CYC)
	) u_led (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_up     (link_s2_q),
		.i_act    (act),
		.o_led    (o_link_activity_indicator)
	);

	// ==========================================================
	// Checks
	property p_no_overflow;
		@(posedge i_clk) disable iff (!i_resetn)
		push[1] |-> cnt_q[1] < CW'(DEPTH);
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("push into full queue");

	property p_strict;
		@(posedge i_clk) disable iff (!i_resetn)
		load[0] && strict && hi_ne[0] |=> o_tx_high[0];
	endproperty
	a_strict: assert property (p_strict)
		else $error("low sent while high waits in strict mode");

	property p_ratio_low;
		@(posedge i_clk) disable iff (!i_resetn)
		load[0] && !strict && rc_q[0] == ratio && lo_ne[0]
			|=> !o_tx_high[0] ##0 rc_q[0] == 5'h00;
	endproperty
	a_ratio_low: assert property (p_ratio_low)
		else $error("low not sent after ratio reached");

	property p_ratio_high;
		@(posedge i_clk) disable iff (!i_resetn)
		load[0] && !strict && hi_ne[0] && rc_q[0] < ratio
			|=> o_tx_high[0] ##0 rc_q[0] == $past(rc_q[0]) + 5'h01;
	endproperty
	a_ratio_high: assert property (p_ratio_high)
		else $error("high not sent before ratio reached");

	property p_no_idle;
		@(posedge i_clk) disable iff (!i_resetn)
		!o_tx_valid[0] && (hi_ne[0] || lo_ne[0]) |=> o_tx_valid[0];
	endproperty
	a_no_idle: assert property (p_no_idle)
		else $error("port idle with packets waiting");

	property p_port_high;
		@(posedge i_clk) disable iff (!i_resetn)
		acc && en_port[i_pkt_port] |-> tgt[0];
	endproperty
	a_port_high: assert property (p_port_high)
		else $error("port priority packet sent low");

	property p_pcp_high;
		@(posedge i_clk) disable iff (!i_resetn)
		acc && en_pcp[i_pkt_port] && i_pkt_tagged &&
		i_pkt_pcp >= ctrl_q[sqc_pkg::CTL_THR_LSB +: 3] |-> tgt[0];
	endproperty
	a_pcp_high: assert property (p_pcp_high)
		else $error("user priority at threshold sent low");

	property p_dscp_ef;
		@(posedge i_clk) disable iff (!i_resetn)
		acc && en_dscp[i_pkt_port] && i_pkt_is_ip &&
		i_pkt_dscp == sqc_pkg::DSCP_EF |-> tgt[0];
	endproperty
	a_dscp_ef: assert property (p_dscp_ef)
		else $error("fixed code point sent low");

	property p_user_cp;
		@(posedge i_clk) disable iff (!i_resetn)
		acc && en_dscp[i_pkt_port] && i_pkt_is_ip &&
		ctrl_q[sqc_pkg::CTL_UCPA_EN] &&
		i_pkt_dscp == ucp_q[sqc_pkg::UCP_A_LSB +: 6] |-> tgt[0];
	endproperty
	a_user_cp: assert property (p_user_cp)
		else $error("user code point sent low");

	property p_net;
		@(posedge i_clk) disable iff (!i_resetn)
		acc && i_pkt_is_ip && ctrl_q[sqc_pkg::CTL_NETA_EN] &&
		((i_pkt_dst_ip ^ neta_addr_q) & neta_mask_q) == 32'h0000_0000
		|-> tgt[0];
	endproperty
	a_net: assert property (p_net)
		else $error("network member sent low");

	property p_plain_low;
		@(posedge i_clk) disable iff (!i_resetn)
		acc && !i_pkt_is_ip && !i_pkt_tagged &&
		!en_port[i_pkt_port] |-> !tgt[0];
	endproperty
	a_plain_low: assert property (p_plain_low)
		else $error("untagged non-IP packet sent high");

endmodule

// File: sqc_tx_model.sv
// Egress transmitter model: takes handles unless stalled, logs port 0.
// Assumes the same clock as the QoS block.
module sqc_tx_model #(
	parameter int unsigned NP  = 8,
	parameter int unsigned IDW = 8
) (
	// Clock
	input  wire logic              i_clk,
	// Handles offered
	input  wire logic [NP-1:0]     i_valid,
	input  wire logic [NP-1:0]     i_high,
	input  wire logic [NP*IDW-1:0] i_id,
	// Stall control and answer
	input  wire logic [NP-1:0]     i_stall,
	output logic      [NP-1:0]     o_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	// =====================================================
	// Take and log
	logic [IDW:0] log_q [$];
	assign o_ready = ~i_stall;
	always @(posedge i_clk) begin
		if (i_valid[0] && o_ready[0])
			log_q.push_back({i_high[0], i_id[IDW-1:0]});
	end
endmodule

// File: sqc_top_tb_top.sv
// Testbench of the QoS block: registers, classes, order, indicator.
// Assumes the transmitter model on the egress side, 100 MHz clock.
module sqc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0]  port;
		logic        tag;
		logic [2:0]  pcp;
		logic        ip;
		logic [5:0]  dscp;
		logic [31:0] src;
		logic [31:0] dst;
		logic        hi;
	} sqc_row_t;
	// =====================================================
	// Signals
	logic        clk = 0;
	logic        resetn = 0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 0;
	logic        rd = 0;
	logic [31:0] rdata;
	logic        pv = 0;
	logic        prdy;
	logic [2:0]  pegr = 3'h0;
	logic [7:0]  pid = 8'h00;
	sqc_row_t    cur = '0;
	sqc_row_t    r;
	logic [7:0]  txv, txh, txr, led, lup = 8'h00, stall = 8'h00;
	logic [63:0] txid;
	int          err_total = 0;
	int          total_checks = 0;
	int          tog;
	logic        prev;
	logic [5:0]  cps [7] = '{6'h2E, 6'h0A, 6'h12, 6'h1A, 6'h22, 6'h38, 6'h30};
	logic [7:0]  ord [4] = '{8'hF6, 8'hFC, 8'hFC, 8'hFC};
	sqc_row_t    rows [11] = '{
		'{3'h1, 1'h0, 3'h0, 1'h0, 6'h00, 32'h0, 32'h0, 1'h1},
		'{3'h0, 1'h1, 3'h7, 1'h0, 6'h00, 32'h0, 32'h0, 1'h0},
		'{3'h2, 1'h1, 3'h5, 1'h0, 6'h00, 32'h0, 32'h0, 1'h1},
		'{3'h2, 1'h1, 3'h4, 1'h0, 6'h00, 32'h0, 32'h0, 1'h0},
		'{3'h2, 1'h0, 3'h7, 1'h0, 6'h00, 32'h0, 32'h0, 1'h0},
		'{3'h3, 1'h0, 3'h0, 1'h1, 6'h05, 32'h0, 32'h0, 1'h1},
		'{3'h3, 1'h0, 3'h0, 1'h1, 6'h07, 32'h0, 32'h0, 1'h0},
		'{3'h3, 1'h0, 3'h0, 1'h0, 6'h2E, 32'h0, 32'h0, 1'h0},
		'{3'h0, 1'h0, 3'h0, 1'h1, 6'h2E, 32'h0A01_0203, 32'h0, 1'h1},
		'{3'h0, 1'h0, 3'h0, 1'h1, 6'h00, 32'h0, 32'h0AFF_0001, 1'h1},
		'{3'h0, 1'h0, 3'h0, 1'h0, 6'h00, 32'h0A01_0203, 32'h0B00_0001, 1'h0}};
	// =====================================================
	// Design and transmitter model
	sqc_top #(.HALF_CYC(16)) sqc_top_inst (
		.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pkt_valid(pv),
		.o_pkt_ready(prdy), .i_pkt_port(cur.port), .i_pkt_egress(pegr),
		.i_pkt_id(pid), .i_pkt_tagged(cur.tag), .i_pkt_pcp(cur.pcp),
		.i_pkt_is_ip(cur.ip), .i_pkt_dscp(cur.dscp), .i_pkt_src_ip(cur.src),
		.i_pkt_dst_ip(cur.dst), .o_tx_valid(txv), .o_tx_high(txh),
		.o_tx_id(txid), .i_tx_ready(txr), .i_link_up(lup),
		.o_link_activity_indicator(led));
	sqc_tx_model sqc_tx_model_inst (.i_clk(clk), .i_valid(txv),
		.i_high(txh), .i_id(txid), .i_stall(stall), .o_ready(txr));
	initial begin
		forever #5 clk = ~clk;
	end
	// =====================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	task automatic send(input sqc_row_t x, input logic [7:0] id,
		input logic [2:0] eg);
		@(posedge clk);
		cur <= x;
		pid <= id;
		pegr <= eg;
		pv <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		pv <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// =====================================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
	// =====================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rdc(sqc_pkg::OFS_CTRL, sqc_pkg::CTRL_RST);
		rdc(sqc_pkg::OFS_PORT_EN, sqc_pkg::PEN_RST);
		rdc(sqc_pkg::OFS_NETA_MASK, sqc_pkg::MASK_RST);
		rdc(8'h20, 32'h0);
		chk("led_down", led, 8'h00);
		wrr(sqc_pkg::OFS_CTRL, 32'hFFFF_FFFF);
		rdc(sqc_pkg::OFS_CTRL, sqc_pkg::CTRL_WMASK);
		wrr(sqc_pkg::OFS_CTRL, 32'h0000_0553);
		wrr(sqc_pkg::OFS_PORT_EN, 32'h0008_0402);
		wrr(sqc_pkg::OFS_USER_CP, 32'h0000_0705);
		wrr(sqc_pkg::OFS_NETA_ADDR, 32'h0A00_0000);
		wrr(sqc_pkg::OFS_NETA_MASK, 32'hFF00_0000);
		wrr(sqc_pkg::OFS_NETB_ADDR, 32'h0B00_0000);
		wrr(sqc_pkg::OFS_NETB_MASK, 32'hFF00_0000);
		r = rows[5];
		foreach (cps[k]) begin
			r.dscp = cps[k];
			send(r, 8'(k), 3'h0);
			repeat (4) @(posedge clk);
			chk("codepoint", sqc_tx_model_inst.log_q.pop_front(), {1'b1, 8'(k)});
		end
		// Last row is low, so the ratio count starts from zero below
		foreach (rows[i]) begin
			send(rows[i], 8'(i), 3'h0);
			repeat (4) @(posedge clk);
			chk("class", sqc_tx_model_inst.log_q.pop_front(), {rows[i].hi, 8'(i)});
		end
		for (int m = 0; m < 4; m++) begin
			wrr(sqc_pkg::OFS_CTRL, 32'h0000_0550 | m);
			stall <= 8'h01;
			for (int k = 0; k < 8; k++) begin
				r = '0;
				r.port = (k < 6) ? 3'h1 : 3'h0;
				send(r, 8'(k), 3'h0);
			end
			rdc(sqc_pkg::OFS_STATUS, 32'h0000_0101);
			stall <= 8'h00;
			repeat (16) @(posedge clk);
			for (int k = 0; k < 8; k++)
				chk("order", sqc_tx_model_inst.log_q.pop_front() >> 8, ord[m][7-k]);
		end
		lup <= 8'hFF;
		repeat (60) @(posedge clk);
		chk("led_idle", led[5], 1'b1);
		tog = 0;
		prev = led[4];
		r = '0;
		r.port = 3'h4;
		for (int k = 0; k < 40; k++) begin
			send(r, 8'(k), 3'h4);
			repeat (2) @(posedge clk);
			if (led[4] !== prev)
				tog++;
			prev = led[4];
			chk("led_steady", led[5], 1'b1);
		end
		chk("led_blink", 32'(tog >= 2), 32'h1);
		lup <= 8'h00;
		repeat (6) @(posedge clk);
		chk("led_off", led, 8'h00);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rdc(sqc_pkg::OFS_CTRL, sqc_pkg::CTRL_RST);
		tally_and_finish();
	end
endmodule
